// [logic/cfs_pkg.sv]
package cfs_pkg;
  // ==========================================================
  // Host register offsets
  localparam logic [3:0] CFS_REG_CTRL = 4'h0;
  localparam logic [3:0] CFS_REG_WDSEL = 4'h1;
  localparam logic [3:0] CFS_REG_OCP = 4'h2;
  localparam logic [3:0] CFS_REG_MASK = 4'h3;
  localparam logic [3:0] CFS_REG_EVENT = 4'h4;
  localparam logic [3:0] CFS_REG_STATUS = 4'h5;
  localparam logic [3:0] CFS_REG_UNLOCK = 4'h6;
  localparam logic [3:0] CFS_REG_STATE = 4'h7;
  // ==========================================================
  // Control register bit positions
  localparam int CFS_C_REV = 0;
  localparam int CFS_C_BYP = 1;
  localparam int CFS_C_WDEN = 2;
  localparam int CFS_C_WDDIS = 3;
  localparam int CFS_C_IRQEN = 4;
  localparam int CFS_C_LVL = 5;
  localparam int CFS_C_CYCACT = 6;
  localparam int CFS_C_STAGE = 7;
  // ==========================================================
  // Event bit positions
  localparam int CFS_E_OV = 0;
  localparam int CFS_E_UV = 1;
  localparam int CFS_E_OT = 2;
  localparam int CFS_E_OC = 3;
  localparam int CFS_E_WD = 4;
  localparam int CFS_E_PG = 5;
  localparam int CFS_E_BOOT = 6;
  localparam int CFS_E_CFLY = 7;
  localparam int CFS_E_TMR = 8;
  localparam int CFS_NEV = 9;
  // ==========================================================
  // Unlock access and timing
  localparam logic [15:0] CFS_UNLOCK_ADDR = 16'hb541;
  localparam logic [7:0] CFS_UNLOCK_KEY = 8'h3d;
  localparam logic [7:0] CFS_CTRL_RST = 8'h80;
  localparam int CFS_CLK_MHZ = 100;
  localparam int CFS_FAULT_DWELL_US = 10;
  localparam int CFS_DWELL_CYC = CFS_FAULT_DWELL_US * CFS_CLK_MHZ;
  typedef enum logic [2:0] {
    CFS_POWERDOWN, CFS_STANDBY, CFS_STARTUP, CFS_ACTIVE, CFS_FAULT
  } cfs_state_e;
endpackage

// [logic/cfs_link_if.sv]
`timescale 1ns/100ps
// Serial control bus abstracted to word transfers, plus key pin
interface cfs_link_if;
  logic wr;
  logic rd;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [15:0] rdata;
  logic key_level;
  logic irq_drive;
  logic irq_n;
  assign irq_n = ~irq_drive;
  modport device (input wr, input rd, input addr, input wdata,
    input key_level, output rdata, output irq_drive);
  modport host (output wr, output rd, output addr, output wdata,
    output key_level, input rdata, input irq_n);
endinterface

// [logic/cfs_device.sv]
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - Direction bit selects sense input for comparators
// - Mode bits frozen while stage runs
// - Over-voltage disables stage, sets event
// - Under-voltage disables stage, sets event
// - Ratio comparator low in active gives fault
// - Limit field chosen by switching or passthrough
// - Over-current latches off, switches high impedance
// - Capacitor short reported as ratio fault
// - Bootstrap loss faults only in passthrough
// - Critical heat faults while heat input stays high
// - Transition timer expiry flags fault, stage off
// - Watchdog runs in active, loads period
// - Period write restarts watchdog count
// - Watchdog expiry sets event, flag, disables
// - Watchdog enable and period locked until key written
// - Interrupt low on unmasked event, gated
// - Masks suppress only the interrupt
// - Write one clears events, interrupt holds
// - Status flags block or disable stage
// - Key press wakes once per press
// - Long press power-cycles to chosen state
// - Level mode follows key pin level
// - Fault dwell, then wait faults clear
module cfs_device
  import cfs_pkg::*;
#(
  parameter int DWELL_CYC = CFS_DWELL_CYC,
  parameter int LONG_PRESS_CYC = 1000000,
  parameter int BOOT_DEB_CYC = 1000,
  parameter int TRANS_CYC = 2000,
  parameter int WD_UNIT_CYC = 100000
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  cfs_link_if.device link,
  input wire logic high_side_sense_ov_in,
  input wire logic high_side_sense_uv_in,
  input wire logic low_side_sense_ov_in,
  input wire logic low_side_sense_uv_in,
  input wire logic ratio_comparator_up_in,
  input wire logic ratio_comparator_down_in,
  input wire logic [1:0] phase_current_over_in,
  input wire logic bootstrap_charged_in,
  input wire logic thermal_critical_in,
  input wire logic capacitor_short_in,
  input wire logic stage_ready_in,
  output logic [2:0] overcurrent_limit_out,
  output logic charge_pump_stage_on_out,
  output logic switches_hiz_out,
  output logic passthrough_out,
  output logic power_flow_reverse_out,
  output logic thermal_comp_on_out,
  output logic [2:0] state_out
);
  // ==========================================================
  // Registers
  cfs_state_e state;
  logic [7:0] ctrl;
  logic [7:0] wd_sel;
  logic [5:0] ocp;
  logic [CFS_NEV-1:0] mask;
  logic [CFS_NEV-1:0] event_bits;
  logic unlocked;
  logic rev_live;
  logic byp_live;
  logic wd_flag;
  logic oc_latch;
  logic ot_hold;
  logic key_prev;
  logic key_armed;
  logic [31:0] wd_cnt;
  logic [31:0] key_cnt;
  logic [31:0] boot_cnt;
  logic [31:0] tmr_cnt;
  logic [31:0] dwell_cnt;
  logic [CFS_NEV-1:0] ev_set;
  logic ov;
  logic uv;
  logic pg_bad;
  logic boot_fault;
  logic tmr_fault;
  logic wd_expire;
  logic any_fault;
  logic running;
  logic long_press;
  logic wr_ctrl;
  logic wr_wdsel;
  logic key_rise;
  logic key_wake;

  assign running = (state == CFS_ACTIVE) || (state == CFS_STARTUP);
  assign wr_ctrl = link.wr && link.addr == 16'(CFS_REG_CTRL);
  assign wr_wdsel = link.wr && link.addr == 16'(CFS_REG_WDSEL);
  assign key_rise = link.key_level && !key_prev;
  assign key_wake = key_armed && link.key_level;

  // ==========================================================
  // Comparator routing and faults
  assign ov = rev_live ? low_side_sense_ov_in : high_side_sense_ov_in;
  assign uv = rev_live ? low_side_sense_uv_in : high_side_sense_uv_in;
  assign overcurrent_limit_out = byp_live ? ocp[5:3] : ocp[2:0];
  assign pg_bad = (state == CFS_ACTIVE && (!ratio_comparator_up_in ||
    !ratio_comparator_down_in)) || (running && capacitor_short_in);
  assign boot_fault = (state == CFS_ACTIVE) && byp_live &&
    boot_cnt >= 32'(BOOT_DEB_CYC);
  assign tmr_fault = state == CFS_STARTUP &&
    tmr_cnt >= 32'(TRANS_CYC) && !stage_ready_in;
  assign wd_expire = state == CFS_ACTIVE && ctrl[CFS_C_WDEN] &&
    wd_cnt == 32'd0 && !ctrl[CFS_C_WDDIS];
  assign long_press = state == CFS_ACTIVE && !ctrl[CFS_C_LVL] &&
    key_cnt >= 32'(LONG_PRESS_CYC);
  assign any_fault = ov || uv || ot_hold || oc_latch || wd_flag ||
    pg_bad || boot_fault || tmr_fault;

  assign ev_set[CFS_E_OV] = ov;
  assign ev_set[CFS_E_UV] = uv;
  assign ev_set[CFS_E_OT] = thermal_comp_on_out && thermal_critical_in;
  assign ev_set[CFS_E_OC] = running && |phase_current_over_in;
  assign ev_set[CFS_E_WD] = wd_expire;
  assign ev_set[CFS_E_PG] = pg_bad || (running && capacitor_short_in);
  assign ev_set[CFS_E_BOOT] = boot_fault;
  assign ev_set[CFS_E_CFLY] = running && capacitor_short_in;
  assign ev_set[CFS_E_TMR] = tmr_fault;

  // ==========================================================
  // Host writes
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl <= CFS_CTRL_RST;
      wd_sel <= 8'h00;
      ocp <= 6'h00;
      mask <= '0;
      unlocked <= 1'b0;
    end else if (link.wr) begin
      if (link.addr == CFS_UNLOCK_ADDR) begin
        unlocked <= link.wdata == CFS_UNLOCK_KEY;
      end
      if (wr_ctrl) begin
        ctrl[CFS_C_WDEN] <= unlocked ? link.wdata[CFS_C_WDEN]
          : ctrl[CFS_C_WDEN];
        ctrl[CFS_C_REV] <= link.wdata[CFS_C_REV];
        ctrl[CFS_C_BYP] <= link.wdata[CFS_C_BYP];
        ctrl[CFS_C_WDDIS] <= link.wdata[CFS_C_WDDIS];
        ctrl[CFS_C_IRQEN] <= link.wdata[CFS_C_IRQEN];
        ctrl[CFS_C_LVL] <= link.wdata[CFS_C_LVL];
        ctrl[CFS_C_CYCACT] <= link.wdata[CFS_C_CYCACT];
        ctrl[CFS_C_STAGE] <= link.wdata[CFS_C_STAGE];
      end
      if (wr_wdsel && unlocked) begin
        wd_sel <= link.wdata;
      end
      if (link.addr == 16'(CFS_REG_OCP)) begin
        ocp <= link.wdata[5:0];
      end
      if (link.addr == 16'(CFS_REG_MASK)) begin
        mask <= {link.wdata[0], link.wdata};
      end
    end
  end

  // ==========================================================
  // Live mode bits, latched only while stage is off
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rev_live <= 1'b0;
      byp_live <= 1'b0;
    end else if (!running) begin
      rev_live <= ctrl[CFS_C_REV];
      byp_live <= ctrl[CFS_C_BYP];
    end
  end

  // ==========================================================
  // Events, set wins over clear
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      event_bits <= '0;
    end else begin
      event_bits <= (event_bits & ~((link.wr &&
        link.addr == 16'(CFS_REG_EVENT)) ?
        {link.wdata[0], link.wdata} : '0)) | ev_set;
    end
  end

  assign link.irq_drive = ctrl[CFS_C_IRQEN] &&
    |(event_bits & ~mask);

  // ==========================================================
  // Latched faults and registered heat flag
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      oc_latch <= 1'b0;
      ot_hold <= 1'b0;
      wd_flag <= 1'b0;
    end else begin
      if (running && |phase_current_over_in) begin
        oc_latch <= 1'b1;
      end else if (state == CFS_FAULT && dwell_cnt == 32'd0) begin
        oc_latch <= 1'b0;
      end
      if (thermal_comp_on_out && thermal_critical_in) begin
        ot_hold <= 1'b1;
      end else if (!thermal_comp_on_out || !thermal_critical_in) begin
        ot_hold <= 1'b0;
      end
      if (wd_expire) begin
        wd_flag <= 1'b1;
      end else if (wr_wdsel) begin
        wd_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Watchdog
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wd_cnt <= 32'd0;
    end else if (state != CFS_ACTIVE || !ctrl[CFS_C_WDEN] ||
        wr_wdsel) begin
      wd_cnt <= (32'(wd_sel) + 32'd1) * 32'(WD_UNIT_CYC);
    end else if (wd_cnt != 32'd0) begin
      wd_cnt <= wd_cnt - 32'd1;
    end
  end

  // ==========================================================
  // Counters: bootstrap, transition timer, key
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boot_cnt <= 32'd0;
      tmr_cnt <= 32'd0;
      key_cnt <= 32'd0;
      key_prev <= 1'b0;
      key_armed <= 1'b0;
    end else begin
      boot_cnt <= (state == CFS_ACTIVE && byp_live && !bootstrap_charged_in)
        ? boot_cnt + 32'd1 : 32'd0;
      tmr_cnt <= state == CFS_STARTUP ? tmr_cnt + 32'd1 : 32'd0;
      key_cnt <= link.key_level ? key_cnt + 32'd1 : 32'd0;
      key_prev <= link.key_level;
      if (key_rise) begin
        key_armed <= 1'b1;
      end else if (!link.key_level || (state == CFS_POWERDOWN &&
          !ctrl[CFS_C_LVL])) begin
        key_armed <= 1'b0;
      end
    end
  end

  // ==========================================================
  // State machine
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= CFS_POWERDOWN;
      dwell_cnt <= 32'd0;
    end else begin
      unique case (state)
        CFS_POWERDOWN: begin
          if ((ctrl[CFS_C_LVL] && link.key_level) ||
              (!ctrl[CFS_C_LVL] && key_wake)) begin
            state <= CFS_STANDBY;
          end
        end
        CFS_STANDBY: begin
          if (ctrl[CFS_C_LVL] && !link.key_level) begin
            state <= CFS_POWERDOWN;
          end else if (ctrl[CFS_C_STAGE] && !ov && !uv && !ot_hold &&
              !wd_flag) begin
            state <= CFS_STARTUP;
          end
        end
        CFS_STARTUP: begin
          if (any_fault || |phase_current_over_in) begin
            state <= CFS_FAULT;
            dwell_cnt <= 32'(DWELL_CYC);
          end else if (stage_ready_in) begin
            state <= CFS_ACTIVE;
          end
        end
        CFS_ACTIVE: begin
          if (any_fault || |phase_current_over_in || wd_expire ||
              long_press) begin
            state <= CFS_FAULT;
            dwell_cnt <= 32'(DWELL_CYC);
          end else if (ctrl[CFS_C_LVL] && !link.key_level) begin
            state <= CFS_POWERDOWN;
          end else if (!ctrl[CFS_C_STAGE]) begin
            state <= CFS_STANDBY;
          end
        end
        CFS_FAULT: begin
          if (dwell_cnt != 32'd0) begin
            dwell_cnt <= dwell_cnt - 32'd1;
          end else if (!ov && !uv && !ot_hold && !wd_flag && !oc_latch &&
              !link.key_level) begin
            state <= ctrl[CFS_C_CYCACT] ? CFS_STANDBY : CFS_POWERDOWN;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign charge_pump_stage_on_out = running && !any_fault;
  assign switches_hiz_out = oc_latch || !running;
  assign passthrough_out = byp_live;
  assign power_flow_reverse_out = rev_live;
  assign thermal_comp_on_out = state != CFS_POWERDOWN;
  assign state_out = state;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link.rdata <= 16'h0000;
    end else if (link.rd) begin
      unique case (link.addr)
        16'(CFS_REG_CTRL): link.rdata <= {8'h00, ctrl};
        16'(CFS_REG_WDSEL): link.rdata <= {8'h00, wd_sel};
        16'(CFS_REG_OCP): link.rdata <= {10'h000, ocp};
        16'(CFS_REG_MASK): link.rdata <= {7'h00, mask};
        16'(CFS_REG_EVENT): link.rdata <= {7'h00, event_bits};
        16'(CFS_REG_STATUS): link.rdata <= {11'h000, unlocked, ot_hold,
          oc_latch, wd_flag, any_fault};
        16'(CFS_REG_STATE): link.rdata <= {13'h0000, state};
        default: link.rdata <= 16'h0000;
      endcase
    end
  end
endmodule

// [logic/cfs_host.sv]
`timescale 1ns/100ps
module cfs_host
  import cfs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  cfs_link_if.host link,
  input wire logic cmd_wr_in,
  input wire logic cmd_rd_in,
  input wire logic [15:0] cmd_addr_in,
  input wire logic [7:0] cmd_wdata_in,
  input wire logic key_level_in,
  output logic [15:0] cmd_rdata_out,
  output logic irq_active_out
);
  // ==========================================================
  // Drive bus from registered commands
  logic rd_pend;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      link.addr <= 16'h0000;
      link.wdata <= 8'h00;
      link.key_level <= 1'b0;
      rd_pend <= 1'b0;
      cmd_rdata_out <= 16'h0000;
    end else begin
      link.wr <= cmd_wr_in;
      link.rd <= cmd_rd_in;
      link.addr <= cmd_addr_in;
      link.wdata <= cmd_wdata_in;
      link.key_level <= key_level_in;
      rd_pend <= link.rd;
      if (rd_pend) begin
        cmd_rdata_out <= link.rdata;
      end
    end
  end
  assign irq_active_out = !link.irq_n;
endmodule

// [testbench/cfs_link_asserts.sv]
`timescale 1ns/100ps
module cfs_link_asserts
  import cfs_pkg::*;
#(
  parameter int DWELL_CYC = CFS_DWELL_CYC
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] state_out,
  input wire logic charge_pump_stage_on_out,
  input wire logic switches_hiz_out,
  input wire logic passthrough_out,
  input wire logic power_flow_reverse_out,
  input wire logic thermal_comp_on_out,
  input wire logic [2:0] overcurrent_limit_out,
  input wire logic high_side_sense_ov_in,
  input wire logic high_side_sense_uv_in,
  input wire logic low_side_sense_ov_in,
  input wire logic low_side_sense_uv_in,
  input wire logic [1:0] phase_current_over_in,
  input wire logic thermal_critical_in
);
  // ==========================================================
  // Helper logic
  logic [15:0] flt_cnt;
  logic sel_ov;
  logic sel_uv;
  logic in_fault;
  assign in_fault = (state_out == CFS_FAULT);
  assign sel_ov = power_flow_reverse_out ? low_side_sense_ov_in
                                         : high_side_sense_ov_in;
  assign sel_uv = power_flow_reverse_out ? low_side_sense_uv_in
                                         : high_side_sense_uv_in;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flt_cnt <= 16'h0000;
    end else if (in_fault) begin
      flt_cnt <= flt_cnt + 16'h0001;
    end else begin
      flt_cnt <= 16'h0000;
    end
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  sequence ov_held;
    sel_ov [*2];
  endsequence
  sequence latch_off;
    switches_hiz_out && in_fault;
  endsequence
  chk_ov_stage_off: assert property (
    ov_held |-> ##[0:1000] !charge_pump_stage_on_out)
    else $error("stage still on after over-voltage");
  chk_uv_stage_off: assert property (
    sel_uv |-> ##[0:1000] !charge_pump_stage_on_out)
    else $error("stage still on after under-voltage");
  chk_oc_latch_off: assert property (
    (|phase_current_over_in && charge_pump_stage_on_out) |-> ##[0:4] latch_off)
    else $error("no latch-off after over-current");
  chk_heat_fault: assert property (
    (thermal_critical_in && state_out == CFS_ACTIVE) |-> ##[0:4] in_fault)
    else $error("no fault state after critical heat");
  chk_comp_pd_off: assert property (
    (state_out == CFS_POWERDOWN) |-> !thermal_comp_on_out)
    else $error("thermal comparator on in power-down");
  chk_fault_dwell: assert property (
    ($past(in_fault) && !in_fault) |-> (flt_cnt >= DWELL_CYC - 1))
    else $error("fault state left before dwell time");
  chk_mode_frozen: assert property (
    (charge_pump_stage_on_out && $past(charge_pump_stage_on_out)) |->
      ($stable(power_flow_reverse_out) && $stable(passthrough_out)))
    else $error("mode changed while stage running");
  chk_limit_select: assert property (
    (wr && addr == {12'h000, CFS_REG_OCP}) ##1 charge_pump_stage_on_out |->
      overcurrent_limit_out == (passthrough_out ? $past(wdata[5:3])
                                                : $past(wdata[2:0])))
    else $error("wrong over-current limit field");
  chk_fault_no_run: assert property (
    in_fault |-> !charge_pump_stage_on_out)
    else $error("stage running in fault state");
endmodule

// [testbench/test_converter_fault_supervisor.sv]
`timescale 1ns/100ps
module test_converter_fault_supervisor import cfs_pkg::*;;
  localparam logic [15:0] A_CTRL = {12'h000, CFS_REG_CTRL};
  localparam logic [15:0] A_WDSEL = {12'h000, CFS_REG_WDSEL};
  localparam logic [15:0] A_OCP = {12'h000, CFS_REG_OCP};
  localparam logic [15:0] A_MASK = {12'h000, CFS_REG_MASK};
  localparam logic [15:0] A_EVENT = {12'h000, CFS_REG_EVENT};
  logic mclk_in, reset_n_in, cmd_wr, cmd_rd, key_level, irq_active;
  logic [15:0] cmd_addr, cmd_rdata;
  logic [7:0] cmd_wdata;
  logic hs_ov, hs_uv, ls_ov, ls_uv, thermal, ready;
  logic ratio_up, ratio_dn, boot_ok, cap_short;
  logic [1:0] phase;
  logic [2:0] ocp_lim, state;
  logic stage_on, hiz, pass, rev, tcomp;
  int err_total, checked, k, n;
  logic [15:0] ev_tab [11] = '{16'h0001, 16'h0002, 16'h0008, 16'h0004,
                               16'h0100, 16'h0001, 16'h0010, 16'h0020,
                               16'h00a0, 16'h0040, 16'h0020};
  cfs_link_if u_cfs_link_if ();
  cfs_device #(.DWELL_CYC(10), .LONG_PRESS_CYC(20), .BOOT_DEB_CYC(5),
    .TRANS_CYC(10), .WD_UNIT_CYC(10)) u_cfs_device (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(u_cfs_link_if),
    .high_side_sense_ov_in(hs_ov), .high_side_sense_uv_in(hs_uv),
    .low_side_sense_ov_in(ls_ov), .low_side_sense_uv_in(ls_uv),
    .ratio_comparator_up_in(ratio_up), .ratio_comparator_down_in(ratio_dn),
    .phase_current_over_in(phase), .bootstrap_charged_in(boot_ok),
    .thermal_critical_in(thermal), .capacitor_short_in(cap_short),
    .stage_ready_in(ready), .overcurrent_limit_out(ocp_lim),
    .charge_pump_stage_on_out(stage_on), .switches_hiz_out(hiz),
    .passthrough_out(pass), .power_flow_reverse_out(rev),
    .thermal_comp_on_out(tcomp), .state_out(state));
  cfs_host u_cfs_host (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .link(u_cfs_link_if), .cmd_wr_in(cmd_wr), .cmd_rd_in(cmd_rd),
    .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
    .key_level_in(key_level), .cmd_rdata_out(cmd_rdata),
    .irq_active_out(irq_active));
  cfs_link_asserts #(.DWELL_CYC(10)) u_cfs_link_asserts (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .wr(u_cfs_link_if.wr),
    .addr(u_cfs_link_if.addr), .wdata(u_cfs_link_if.wdata),
    .state_out(state), .charge_pump_stage_on_out(stage_on),
    .switches_hiz_out(hiz), .passthrough_out(pass),
    .power_flow_reverse_out(rev), .thermal_comp_on_out(tcomp),
    .overcurrent_limit_out(ocp_lim), .high_side_sense_ov_in(hs_ov),
    .high_side_sense_uv_in(hs_uv), .low_side_sense_ov_in(ls_ov),
    .low_side_sense_uv_in(ls_uv), .phase_current_over_in(phase),
    .thermal_critical_in(thermal));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    cmd_wr <= 1'b1;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge mclk_in);
    cmd_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, exp);
    @(posedge mclk_in);
    cmd_rd <= 1'b1;
    cmd_addr <= a;
    @(posedge mclk_in);
    cmd_rd <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk("register read", cmd_rdata, exp);
  endtask
  task automatic set_fault(input int i, input logic v);
    case (i)
      0: hs_ov <= v;
      1: ls_uv <= v;
      2: phase <= {1'b0, v};
      3: thermal <= v;
      4: ready <= !v;
      5: ls_ov <= v;
      7: ratio_up <= !v;
      8: cap_short <= v;
      9: boot_ok <= !v;
      10: ratio_dn <= !v;
      default: ;
    endcase
  endtask
  task automatic go_active(input logic want);
    if (state === CFS_POWERDOWN) begin
      chk("comparator power", {15'h0, tcomp}, 16'h0000);
      key_level <= 1'b1;
      repeat (5) @(posedge mclk_in);
      key_level <= 1'b0;
    end
    for (n = 0; want && n < 300 && state !== CFS_ACTIVE; n++)
      @(posedge mclk_in);
    if (want) chk("state", {13'h0, state}, 16'h0003);
  endtask
  task automatic fault_run(input int i);
    if (i == 9) wr_reg(A_CTRL, 8'h93);
    if (i == 4) set_fault(i, 1'b1);
    go_active(i != 4);
    if (i == 9) chk("limit pass", {13'h0, ocp_lim}, 16'h0005);
    if (i == 1) begin
      chk("reverse applied", {15'h0, rev}, 16'h0001);
      hs_ov <= 1'b1;
      hs_uv <= 1'b1;
      repeat (30) @(posedge mclk_in);
      chk("other side", {15'h0, irq_active}, 16'h0000);
      hs_ov <= 1'b0;
      hs_uv <= 1'b0;
    end
    if (i == 2) begin
      wr_reg(A_OCP, 8'h2a);
      repeat (2) @(posedge mclk_in);
      chk("limit", {13'h0, ocp_lim}, 16'h0002);
    end
    if (i == 6) begin
      wr_reg(A_CTRL, 8'h95);
      rd_reg(A_CTRL, 16'h0091);
      wr_reg(CFS_UNLOCK_ADDR, CFS_UNLOCK_KEY);
      wr_reg(A_CTRL, 8'h95);
      for (n = 0; n < 12; n++) wr_reg(A_WDSEL, 8'h00);
      chk("refreshed", {15'h0, irq_active}, 16'h0000);
      rd_reg(A_CTRL, 16'h0095);
    end
    if (i != 4) set_fault(i, 1'b1);
    for (n = 0; n < 2000 && irq_active !== 1'b1; n++) @(posedge mclk_in);
    if (i == 2) chk("switches off", {15'h0, hiz}, 16'h0001);
    set_fault(i, 1'b0);
    if (i == 6) begin
      wr_reg(A_CTRL, 8'h91);
      wr_reg(A_WDSEL, 8'h00);
    end
    for (n = 0; n < 300 && state === CFS_FAULT; n++) @(posedge mclk_in);
    rd_reg(A_EVENT, ev_tab[i]);
    chk("irq raised", {15'h0, irq_active}, 16'h0001);
    if (i != 4) begin
      wr_reg(A_MASK, 8'hff);
      repeat (4) @(posedge mclk_in);
      chk("irq masked", {15'h0, irq_active}, 16'h0000);
      rd_reg(A_EVENT, ev_tab[i]);
    end
    wr_reg(A_EVENT, 8'hff);
    wr_reg(A_MASK, 8'h00);
    rd_reg(A_EVENT, 16'h0000);
    chk("irq released", {15'h0, irq_active}, 16'h0000);
    $display("test %0d done", i);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog and test sequence
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (60000) @(posedge mclk_in);
    err_total++;
    end_sim;
  end
  initial begin
    {reset_n_in, cmd_wr, cmd_rd, key_level, hs_ov, hs_uv} = 6'h00;
    {ls_ov, ls_uv, thermal, phase, cmd_addr, cmd_wdata} = 29'h0;
    {ready, ratio_up, ratio_dn, boot_ok, cap_short} = 5'b11110;
    err_total = 0;
    checked = 0;
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    rd_reg(16'h0007, 16'h0000);
    rd_reg(16'h0100, 16'h0000);
    wr_reg(A_CTRL, 8'h90);
    go_active(1'b1);
    wr_reg(A_CTRL, 8'h91);
    repeat (3) @(posedge mclk_in);
    chk("reverse held", {15'h0, rev}, 16'h0000);
    for (k = 0; k < 11; k++) fault_run(k);
    wr_reg(A_CTRL, 8'hd3);
    go_active(1'b1);
    key_level <= 1'b1;
    repeat (30) @(posedge mclk_in);
    chk("long press", {13'h0, state}, 16'h0004);
    key_level <= 1'b0;
    go_active(1'b1);
    $display("test %0d done", 11);
    key_level <= 1'b1;
    wr_reg(A_CTRL, 8'hf3);
    key_level <= 1'b0;
    repeat (6) @(posedge mclk_in);
    chk("level low", {13'h0, state}, 16'h0000);
    key_level <= 1'b1;
    repeat (8) @(posedge mclk_in);
    chk("level high", {13'h0, state}, 16'h0003);
    $display("test %0d done", 12);
    end_sim;
  end
endmodule
